// File: drive_mode_pkg.sv
// Purpose: shared constants and types for the special drive mode selector
// Assumes: 250 MHz pclk, 10-bit analog sample spanning 0..10 V
// Notes: register byte addresses are word aligned on APB
package drive_mode_pkg;
    localparam int unsigned ADC_BITS = 10;
    localparam int unsigned SPEED_BITS = 16;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SCALE = 12'h008;
    localparam logic [11:0] ADDR_TARGET = 12'h00c;
    localparam logic [3:0] SWITCH_DEFAULT = 4'h1;
    localparam logic [31:0] SCALE_RESET = 32'h0001_0001;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_CFGDONE_BIT = 1;
    localparam logic [15:0] RPM_FAST = 16'h03e8;
    localparam logic [15:0] RPM_SLOW = 16'h0064;
    localparam logic [15:0] RPM_TEST = 16'h001e;
    localparam int unsigned FULL_SCALE_MV = 10000;
    localparam int unsigned DEAD_MV = 20;
    // dead band in analog counts, rounded down so it never exceeds 20 mV
    localparam int unsigned DEAD_COUNTS = (DEAD_MV * 1023) / FULL_SCALE_MV;
    localparam logic [9:0] ADC_MAX = 10'h3ff;
    localparam logic [9:0] ADC_HALF = 10'h200;
    localparam logic [9:0] ADC_DEAD = 10'(DEAD_COUNTS);

    typedef enum logic [1:0] {
        MODE_STEP_DIR,
        MODE_TEST_RUN,
        MODE_ANALOG
    } drive_mode_e;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_STEP_DIR,
        OP_VELOCITY
    } op_mode_e;
endpackage

// File: drive_mode_selector.sv
// Purpose: special drive mode selector with APB registers
// Assumes: all inputs synchronous to pclk; software sets cfg done after loading config
// Notes: target speed appears one cycle after its inputs settle, two cycles after the analog sample
`timescale 1ns/1ns
module drive_mode_selector (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host inputs
    input wire logic [3:0] coding_switch,
    input wire logic enable_in,
    input wire logic step_in,
    input wire logic direction_in,
    input wire logic [drive_mode_pkg::ADC_BITS-1:0] analog_in,
    // motion outputs
    output drive_mode_pkg::op_mode_e op_mode,
    output logic closed_loop,
    output logic motion_enable,
    output logic step_out,
    output logic direction_out,
    output logic signed [16:0] target_speed,
    output logic program_start
);
    mode_cfg_if cfg ();

    logic ctrl_enable_reg;
    logic cfg_done_reg;
    logic [31:0] scale_reg;
    logic [3:0] switch_latched;
    logic latched;
    logic latched_d_reg;
    logic signed [16:0] analog_speed;
    logic signed [16:0] target_next;
    logic apb_access;
    logic addr_ok;

    assign apb_access = psel & penable;

    // registers always answer in the first access cycle
    assign pready = 1'b1;

    function automatic logic addr_known(input logic [11:0] a);
        return a == drive_mode_pkg::ADDR_CTRL || a == drive_mode_pkg::ADDR_STATUS ||
               a == drive_mode_pkg::ADDR_SCALE || a == drive_mode_pkg::ADDR_TARGET;
    endfunction

    assign addr_ok = addr_known(paddr);
    assign pslverr = apb_access & ~addr_ok;

    // modes stay enabled unless software clears the bit before or in the same write that sets cfg done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_enable_reg <= 1'b1;
            cfg_done_reg <= 1'b0;
            scale_reg <= drive_mode_pkg::SCALE_RESET;
        end else if (apb_access && pwrite) begin
            if (paddr == drive_mode_pkg::ADDR_CTRL) begin
                // the enable bit is frozen once cfg done is set
                if (!cfg_done_reg) begin
                    ctrl_enable_reg <= pwdata[drive_mode_pkg::CTRL_ENABLE_BIT];
                end
                cfg_done_reg <= cfg_done_reg | pwdata[drive_mode_pkg::CTRL_CFGDONE_BIT];
            end else if (paddr == drive_mode_pkg::ADDR_SCALE) begin
                scale_reg <= pwdata;
            end
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == drive_mode_pkg::ADDR_CTRL) begin
            prdata[drive_mode_pkg::CTRL_ENABLE_BIT] = ctrl_enable_reg;
            prdata[drive_mode_pkg::CTRL_CFGDONE_BIT] = cfg_done_reg;
        end else if (paddr == drive_mode_pkg::ADDR_STATUS) begin
            prdata = {22'h0, latched, cfg.active, op_mode, closed_loop, motion_enable,
                      switch_latched};
        end else if (paddr == drive_mode_pkg::ADDR_SCALE) begin
            prdata = scale_reg;
        end else if (paddr == drive_mode_pkg::ADDR_TARGET) begin
            prdata = 32'(target_speed);
        end
    end

    switch_decoder u_switch (
        .pclk(pclk),
        .presetn(presetn),
        .cfg_done(cfg_done_reg),
        .modes_enabled(ctrl_enable_reg),
        .coding_switch(coding_switch),
        .cfg(cfg.source),
        .switch_latched(switch_latched),
        .latched(latched)
    );

    velocity_calc u_vel (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg.sink),
        .analog_in(analog_in),
        .direction(direction_in),
        .scale_num(scale_reg[31:16]),
        .scale_den(scale_reg[15:0]),
        .analog_speed(analog_speed)
    );

    // user program starts in the same cycle the switch is latched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_d_reg <= 1'b0;
        end else begin
            latched_d_reg <= latched;
        end
    end
    assign program_start = latched & ~latched_d_reg;

    always_comb begin
        target_next = '0;
        if (cfg.active && enable_in) begin
            case (cfg.mode)
                drive_mode_pkg::MODE_TEST_RUN: begin
                    target_next = cfg.cw ? 17'sd0 + $signed({1'b0, drive_mode_pkg::RPM_TEST})
                                         : -$signed({1'b0, drive_mode_pkg::RPM_TEST});
                end
                drive_mode_pkg::MODE_ANALOG: begin
                    target_next = analog_speed;
                end
                default: begin
                    target_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode <= drive_mode_pkg::OP_NONE;
            closed_loop <= 1'b0;
            motion_enable <= 1'b0;
            step_out <= 1'b0;
            direction_out <= 1'b0;
            target_speed <= '0;
        end else begin
            if (!cfg.active) begin
                op_mode <= drive_mode_pkg::OP_NONE;
            end else if (cfg.mode == drive_mode_pkg::MODE_STEP_DIR) begin
                op_mode <= drive_mode_pkg::OP_STEP_DIR;
            end else begin
                op_mode <= drive_mode_pkg::OP_VELOCITY;
            end
            closed_loop <= cfg.active & cfg.closed_loop;
            motion_enable <= cfg.active & enable_in;
            step_out <= cfg.active & enable_in &
                        (cfg.mode == drive_mode_pkg::MODE_STEP_DIR) & step_in;
            direction_out <= direction_in;
            target_speed <= target_next;
        end
    end

    a_zero_when_off: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_in |=> target_speed == 0 && !motion_enable) else $error("motion while disabled");
    a_enable_follows: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active |=> motion_enable == $past(enable_in)) else $error("enable not followed");
    a_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg.active |=> op_mode == drive_mode_pkg::OP_NONE && target_speed == 0) else $error("modes not suppressed");
    a_test_speed: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active && enable_in && cfg.mode == drive_mode_pkg::MODE_TEST_RUN
        |=> target_speed == 30 || target_speed == -30) else $error("test run speed wrong");
    a_test_cw: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active && enable_in && cfg.mode == drive_mode_pkg::MODE_TEST_RUN && !switch_latched[0]
        |=> target_speed > 0) else $error("test run direction wrong");
    a_step_mode: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active && cfg.mode == drive_mode_pkg::MODE_STEP_DIR
        |=> op_mode == drive_mode_pkg::OP_STEP_DIR && target_speed == 0) else $error("step mode wrong");
    a_loop_bit: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active |=> closed_loop == switch_latched[3]) else $error("loop selection wrong");
    a_normal_dead: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active && enable_in && cfg.mode == drive_mode_pkg::MODE_ANALOG && !cfg.joystick
        && analog_in <= drive_mode_pkg::ADC_DEAD ##1 1 |=> target_speed == 0)
        else $error("normal dead band moved");
    a_joy_dead: assert property (@(posedge pclk) disable iff (!presetn)
        cfg.active && enable_in && cfg.mode == drive_mode_pkg::MODE_ANALOG && cfg.joystick
        && analog_in == drive_mode_pkg::ADC_HALF ##1 1 |=> target_speed == 0)
        else $error("joystick centre not zero");
    a_start_order: assert property (@(posedge pclk) disable iff (!presetn)
        program_start |-> cfg_done_reg && latched) else $error("program started early");

    c_step_mode: cover property (@(posedge pclk) disable iff (!presetn)
        op_mode == drive_mode_pkg::OP_STEP_DIR && step_out);
    c_test_run: cover property (@(posedge pclk) disable iff (!presetn)
        cfg.mode == drive_mode_pkg::MODE_TEST_RUN && target_speed != 0);
    c_joystick_neg: cover property (@(posedge pclk) disable iff (!presetn)
        cfg.joystick && target_speed < 0);
    c_suppressed: cover property (@(posedge pclk) disable iff (!presetn)
        latched && !cfg.active);
endmodule

// File: mode_cfg_if.sv
// Purpose: latched mode configuration passed between selector and velocity unit
// Assumes: single clock domain
// Notes: fields are stable between restarts
`timescale 1ns/1ns
interface mode_cfg_if;
    drive_mode_pkg::drive_mode_e mode;
    logic closed_loop;
    logic joystick;
    logic slow_range;
    logic cw;
    logic active;
    modport source (output mode, closed_loop, joystick, slow_range, cw, active);
    modport sink (input mode, closed_loop, joystick, slow_range, cw, active);
endinterface

// File: motion_host.sv
// Purpose: motion host model driving enable, step, direction and analog pins
// Assumes: commands come from the bench, pins change just after a rising edge
// Notes: step clock runs only while asked to, idling low otherwise
`timescale 1ns/1ns
module motion_host (
    // clock
    input wire logic pclk,
    // commands from the bench
    input wire logic en_cmd,
    input wire logic dir_cmd,
    input wire logic step_run,
    input wire logic [9:0] ana_cmd,
    // device pins
    output logic enable_in = 1'b0,
    output logic step_in = 1'b0,
    output logic direction_in = 1'b0,
    output logic [9:0] analog_in = 10'h000
);
    always @(posedge pclk) begin
        enable_in <= en_cmd;
        direction_in <= dir_cmd;
        analog_in <= ana_cmd;
        // toggling every cycle keeps a stuck step path visible
        step_in <= step_run ? ~step_in : 1'b0;
    end
endmodule

// File: switch_decoder.sv
// Purpose: latch the coding switch once at restart and decode it
// Assumes: configuration is applied before cfg_done rises
// Notes: the switch is sampled only on the first cfg_done after reset
`timescale 1ns/1ns
module switch_decoder (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // startup sequencing
    input wire logic cfg_done,
    input wire logic modes_enabled,
    input wire logic [3:0] coding_switch,
    // decoded configuration
    mode_cfg_if.source cfg,
    output logic [3:0] switch_latched,
    output logic latched
);
    logic [3:0] sw_reg;
    logic done_reg;
    logic en_reg;

    // later switch movement is ignored until the next reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reg <= drive_mode_pkg::SWITCH_DEFAULT;
            done_reg <= 1'b0;
            en_reg <= 1'b0;
        end else if (cfg_done && !done_reg) begin
            sw_reg <= coding_switch;
            en_reg <= modes_enabled;
            done_reg <= 1'b1;
        end
    end

    always_comb begin
        case (sw_reg[2:1])
            2'b00: cfg.mode = drive_mode_pkg::MODE_STEP_DIR;
            2'b01: cfg.mode = drive_mode_pkg::MODE_TEST_RUN;
            default: cfg.mode = drive_mode_pkg::MODE_ANALOG;
        endcase
    end
    assign cfg.closed_loop = sw_reg[3];
    assign cfg.joystick = sw_reg[1];
    assign cfg.slow_range = sw_reg[0];
    assign cfg.cw = ~sw_reg[0];
    assign cfg.active = done_reg & en_reg;
    assign switch_latched = sw_reg;
    assign latched = done_reg;

    a_switch_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        done_reg |=> $stable(sw_reg)) else $error("switch changed after latch");
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the special drive mode selector
// Assumes: zero wait APB slave, switch latched by the cfg done write
// Notes: every mode needs its own reset since the switch latches once
`timescale 1ns/1ns
module testbench;
    typedef struct {int k; logic [31:0] e;} note_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] coding_switch = 4'h1;
    logic en_cmd = 1'b0;
    logic dir_cmd = 1'b0;
    logic step_run = 1'b0;
    logic [9:0] ana_cmd = 10'h000;
    logic enable_in;
    logic step_in;
    logic direction_in;
    logic [9:0] analog_in;
    drive_mode_pkg::op_mode_e op_mode;
    logic closed_loop;
    logic motion_enable;
    logic step_out;
    logic signed [16:0] target_speed;
    logic direction_out;
    logic program_start;
    int starts;
    logic chk = 1'b0;
    logic [31:0] rd_data = 32'h0000_0000;
    logic rd_err = 1'b0;
    int fail_count = 0;
    int checked = 0;
    int seed;
    note_s q[$];
    note_s nt;
    string nm[9] = '{"op_mode", "closed_loop", "target_speed", "motion_enable",
                     "prdata", "pslverr", "step_out", "direction_out", "program_start"};

    always #2 pclk = ~pclk;

    motion_host host (.pclk(pclk), .en_cmd(en_cmd), .dir_cmd(dir_cmd), .step_run(step_run),
        .ana_cmd(ana_cmd), .enable_in(enable_in), .step_in(step_in),
        .direction_in(direction_in), .analog_in(analog_in));

    drive_mode_selector dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .coding_switch(coding_switch), .enable_in(enable_in),
        .step_in(step_in), .direction_in(direction_in), .analog_in(analog_in),
        .op_mode(op_mode), .closed_loop(closed_loop), .motion_enable(motion_enable),
        .step_out(step_out), .direction_out(direction_out), .target_speed(target_speed),
        .program_start(program_start));

    // start pulses since the last reset; exactly one is expected per latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) starts <= 0;
        else if (program_start === 1'b1) starts <= starts + 1;
    end

    function automatic logic [31:0] got(int k);
        case (k)
            0: got = 32'(op_mode);
            1: got = {31'b0, closed_loop};
            2: got = 32'(target_speed);
            3: got = {31'b0, motion_enable};
            4: got = rd_data;
            5: got = {31'b0, rd_err};
            6: got = {31'b0, step_out};
            7: got = {31'b0, direction_out};
            default: got = 32'(starts);
        endcase
    endfunction

    task automatic cmp(int k, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm[k], e, g);
        end
    endtask

    // results are sampled mid-cycle, well clear of the launching edge
    always @(negedge pclk) begin
        if (chk) begin
            while (q.size() > 0) begin
                nt = q.pop_front();
                cmp(nt.k, nt.e, got(nt.k));
            end
        end
    end

    task automatic note(int k, logic [31:0] e);
        q.push_back('{k, e});
    endtask

    task automatic settle(int c);
        repeat (c) @(posedge pclk);
        chk <= 1'b1;
        @(posedge pclk);
        chk <= 1'b0;
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_mode(input logic [3:0] sw);
        logic [31:0] full;
        logic [31:0] spd;
        drive_mode_pkg::op_mode_e op;
        full = sw[0] ? 32'd100 : 32'd1000;
        op = (sw[2] | sw[1]) ? drive_mode_pkg::OP_VELOCITY : drive_mode_pkg::OP_STEP_DIR;
        spd = sw[2] ? (sw[1] ? 32'd0 : full) : (sw[1] ? (sw[0] ? -32'd30 : 32'd30) : 32'd0);
        do_reset();
        coding_switch <= sw;
        en_cmd <= 1'b1;
        dir_cmd <= 1'b1;
        step_run <= 1'b1;
        ana_cmd <= (sw[2] && sw[1]) ? 10'h200 : 10'h3ff;
        apb(1'b1, drive_mode_pkg::ADDR_CTRL, 32'h0000_0003);
        note(0, 32'(op));
        note(1, {31'b0, sw[3]});
        note(2, spd);
        note(3, 32'h0000_0001);
        note(7, 32'h0000_0001);
        note(8, 32'h0000_0001);
        settle(8);
        if (sw[2] && !sw[1]) begin
            dir_cmd <= 1'b0;
            note(2, -full);
            note(7, 32'h0000_0000);
            settle(4);
            apb(1'b0, drive_mode_pkg::ADDR_TARGET, 32'h0000_0000);
            note(4, -full);
            ana_cmd <= 10'($urandom_range(2, 0));
            note(2, 32'h0000_0000);
            settle(4);
        end
        if (sw[2] && sw[1]) begin
            ana_cmd <= 10'h1fe + 10'($urandom_range(4, 0));
            note(2, 32'h0000_0000);
            settle(4);
            ana_cmd <= 10'h000;
            note(2, -full);
            settle(4);
        end
        // switch moves while running; only a restart may pick it up
        en_cmd <= 1'b0;
        coding_switch <= sw ^ 4'($urandom_range(15, 1));
        note(0, 32'(op));
        note(1, {31'b0, sw[3]});
        note(2, 32'h0000_0000);
        note(3, 32'h0000_0000);
        note(6, 32'h0000_0000);
        note(8, 32'h0000_0001);
        settle(4);
        $display("test switch %h done", sw);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        seed = $urandom(35);
        do_reset();
        apb(1'b0, 12'h010, 32'h0000_0000);
        note(4, 32'h0000_0000);
        note(5, 32'h0000_0001);
        settle(0);
        $display("test unmapped read done");
        coding_switch <= 4'h4;
        en_cmd <= 1'b1;
        ana_cmd <= 10'h3ff;
        apb(1'b1, drive_mode_pkg::ADDR_CTRL, 32'h0000_0002);
        note(0, 32'(drive_mode_pkg::OP_NONE));
        note(2, 32'h0000_0000);
        note(8, 32'h0000_0001);
        settle(8);
        $display("test modes disabled done");
        for (int s = 0; s < 16; s++) run_mode(4'(s));
        do_reset();
        coding_switch <= 4'hc;
        en_cmd <= 1'b1;
        dir_cmd <= 1'b1;
        ana_cmd <= 10'h3ff;
        apb(1'b1, drive_mode_pkg::ADDR_SCALE, 32'h0001_0002);
        apb(1'b1, drive_mode_pkg::ADDR_CTRL, 32'h0000_0003);
        note(2, 32'd500);
        settle(8);
        $display("test scale done");
        print_verdict();
    end

    initial begin
        #80000;
        fail_count++;
        print_verdict();
    end
endmodule

// File: velocity_calc.sv
// Purpose: turn the analog sample into a signed target speed
// Assumes: sample is 10-bit unsigned, full scale at all ones
// Notes: scale is numerator/denominator, applied after the range limit
`timescale 1ns/1ns
module velocity_calc #(
    parameter int unsigned ADC_W = drive_mode_pkg::ADC_BITS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs
    mode_cfg_if.sink cfg,
    input wire logic [ADC_W-1:0] analog_in,
    input wire logic direction,
    input wire logic [15:0] scale_num,
    input wire logic [15:0] scale_den,
    // result
    output logic signed [16:0] analog_speed
);
    logic [ADC_W-1:0] mag;
    logic neg;
    logic dead;
    logic [15:0] full;
    logic [31:0] prod;
    logic [47:0] scaled;
    logic [15:0] den_safe;
    logic [47:0] quot;

    always_comb begin
        if (cfg.joystick) begin
            neg = analog_in < drive_mode_pkg::ADC_HALF;
            mag = neg ? drive_mode_pkg::ADC_HALF - analog_in
                      : analog_in - drive_mode_pkg::ADC_HALF;
            dead = mag <= drive_mode_pkg::ADC_DEAD;
            // doubling the lowest sample would wrap to zero, so pin it to the rail
            mag = (mag >= drive_mode_pkg::ADC_HALF) ? drive_mode_pkg::ADC_MAX
                                                     : ADC_W'({mag, 1'b0});
        end else begin
            neg = ~direction;
            mag = analog_in;
            dead = analog_in <= drive_mode_pkg::ADC_DEAD;
        end
        full = cfg.slow_range ? drive_mode_pkg::RPM_SLOW : drive_mode_pkg::RPM_FAST;
        prod = (32'(mag) * 32'(full)) / 32'(drive_mode_pkg::ADC_MAX);
        den_safe = (scale_den == 16'h0000) ? 16'h0001 : scale_den;
        scaled = 48'(prod) * 48'(scale_num);
        quot = scaled / 48'(den_safe);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_speed <= '0;
        end else if (dead) begin
            analog_speed <= '0;
        end else begin
            analog_speed <= neg ? -$signed({1'b0, quot[15:0]}) : $signed({1'b0, quot[15:0]});
        end
    end
endmodule
